// ==== core/sas_pkg.sv ====
package sas_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STACK_PTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EXEC_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RET_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FETCH_CNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_PEND = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_PEND_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_HALT_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_AUX_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_AUX_LAST = 8'h3C;
  // Reset values
  localparam logic [15:0] SP_RESET = 16'h0400;
  localparam logic [15:0] EXEC_RESET = 16'h0000;
  localparam logic [21:0] FETCH_RESET = 22'h3FFFC0;
  localparam logic [21:0] RET_RESET = 22'h000000;
  // Status word fields
  localparam int OFL_HI = 15;
  localparam int OFL_LO = 10;
  localparam int PM_HI = 9;
  localparam int PM_LO = 7;
  localparam int V_BIT = 6;
  localparam int N_BIT = 5;
  localparam int Z_BIT = 4;
  localparam int C_BIT = 3;
  localparam int TC_BIT = 2;
  localparam int OVM_BIT = 1;
  localparam int SXM_BIT = 0;
  // Product shift encodings
  localparam logic [2:0] PM_LEFT1 = 3'h0;
  localparam logic [2:0] PM_NONE = 3'h1;
  localparam logic [2:0] PM_RIGHT_BASE = 3'h1;
  localparam logic [5:0] OFL_ONE = 6'h01;
  localparam logic [15:0] SP_ONE = 16'h0001;

  // Execute-stage request from the core
  typedef struct packed {
    logic spAdj;
    logic [15:0] spDelta;
    logic longCall;
    logic [21:0] callRet;
    logic longRet;
    logic accOflPos;
    logic accOflNeg;
    logic unsignedOp;
    logic unsCarry;
    logic unsBorrow;
    logic cmpOp;
    logic otherOfl;
    logic vTest;
    logic flagWe;
    logic [3:0] flagVal;
    logic auxLowWe;
    logic [2:0] auxIdx;
    logic [15:0] auxLowData;
    logic d2Advance;
    logic [21:0] d2Addr;
    logic d2Busy;
    logic [15:0] irqRaise;
    logic halted;
    logic [31:0] prodIn;
  } sas_core_op_s;

  // Stack memory port
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } sas_mem_s;

  typedef enum logic [2:0] {
    STK_IDLE, STK_WR_HI, STK_RD_HI, STK_RD_LO, STK_RD_DONE
  } sas_stk_e;
endpackage : sas_pkg

// ==== core/sas_regs.sv ====
// Contract
// - Stack addresses are 16 bits; upper address bits are driven zero.
// - Reset loads the stack pointer with 0400 hex.
// - Stack grows upward; pointer names the next empty word.
// - 32-bit pushes write low half first, high half at next address.
// - Stack pointer arithmetic wraps modulo 65536 with no flag.
// - Stack pointer is never forced to even or odd alignment.
// - Eight 32-bit aux pointers; 16-bit writes touch only the low half.
// - 22-bit fetch counter; decode-two instruction finishes before interrupts.
// - Long call saves return address, pushes old one as two halves.
// - Long return branches to saved address, reloads it by two reads.
// - Other calls and returns leave the return address register alone.
// - Status word updates in execute; software can save and restore it.
// - Pending interrupt is serviced only when its mask bit is set.
// - While halted, only interrupts also set in halt mask are serviced.
// - Status layout: tally 15-10, shift 9-7, V 6, flags; reset zero.
// - Signed tally counts accumulator overflows only with saturation off.
// - Positive overflow adds one, negative subtracts one, with V set.
// - Unsigned tally counts carries up and borrows down.
// - Tally wraps 31 to -32 and back; reset clears it.
// - Non-accumulator overflows and compares leave the tally alone.
// - Signed adds increment, subtracts decrement, only with saturation off.
// - V sets on signed overflow, clears on reset or branch test.
// - Shift select: 000 left one, 001 none, others right 1-6 signed.
`timescale 1ns/10ps
`default_nettype none
module sas_regs
  import sas_pkg::*;
#(
  parameter int AUX_N = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core execute side
  input wire sas_core_op_s coreOp,
  input wire logic [15:0] memRdata,
  output sas_mem_s memPort,
  output logic stackBusy,
  output logic branchStb,
  output logic [21:0] branchAddr,
  output logic [31:0] prodOut,
  // Interrupt service
  output logic irqTake,
  output logic [3:0] irqNum
);

  // Storage
  logic [15:0] spReg, spNext;
  logic [15:0] execReg, execNext;
  logic [21:0] retReg, retNext;
  logic [21:0] savedRet, savedNext;
  logic [21:0] fetchReg, branchAddrReg;
  logic [15:0] pendReg, pendNext;
  logic [15:0] maskReg, haltReg;
  logic [31:0] auxReg [AUX_N];
  sas_stk_e stkReg, stkNext;
  sas_mem_s memReg, memNext;
  logic [31:0] prdataReg, prodReg, rdMux;
  logic preadyReg, pslverrReg, irqTakeReg;
  logic branchReg, busyReg;
  logic [3:0] irqNumReg;

  // APB phase decode
  wire logic accPhase = psel & penable;
  wire logic firstAcc = accPhase & ~preadyReg;
  wire logic commit = accPhase & preadyReg;
  wire logic wrCommit = commit & pwrite;
  wire logic isAux = (paddr >= OFF_AUX_BASE) && (paddr <= OFF_AUX_LAST) && (paddr[1:0] == 2'h0);
  wire logic [2:0] auxSel = 3'((paddr - OFF_AUX_BASE) >> 2);
  wire logic spWr = wrCommit && (paddr == OFF_STACK_PTR);
  wire logic exWr = wrCommit && (paddr == OFF_EXEC_STATUS);
  wire logic retWr = wrCommit && (paddr == OFF_RET_ADDR);
  wire logic pendWr = wrCommit && (paddr == OFF_IRQ_PEND);
  wire logic pendClrWr = wrCommit && (paddr == OFF_IRQ_PEND_CLR);
  wire logic maskWr = wrCommit && (paddr == OFF_IRQ_MASK);
  wire logic haltWr = wrCommit && (paddr == OFF_HALT_MASK);
  wire logic auxWr = wrCommit && isAux;
  wire logic mapped = isAux || (paddr == OFF_STACK_PTR) || (paddr == OFF_EXEC_STATUS) ||
      (paddr == OFF_RET_ADDR) || (paddr == OFF_FETCH_CNT) || (paddr == OFF_IRQ_PEND) ||
      (paddr == OFF_IRQ_PEND_CLR) || (paddr == OFF_IRQ_MASK) || (paddr == OFF_HALT_MASK);

  // Read data selection
  always_comb begin
    rdMux = '0;
    if (isAux) begin
      rdMux = auxReg[auxSel];
    end else begin
      case (paddr)
        OFF_STACK_PTR: rdMux = {16'h0000, spReg};
        OFF_EXEC_STATUS: rdMux = {16'h0000, execReg};
        OFF_RET_ADDR: rdMux = {10'h000, retReg};
        OFF_FETCH_CNT: rdMux = {10'h000, fetchReg};
        OFF_IRQ_PEND: rdMux = {16'h0000, pendReg};
        OFF_IRQ_MASK: rdMux = {16'h0000, maskReg};
        OFF_HALT_MASK: rdMux = {16'h0000, haltReg};
        default: rdMux = '0;
      endcase
    end
  end

  // APB answer: one wait state, data held with pready
  always_ff @(posedge clk) begin
    if (rst) begin
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg <= '0;
    end else begin
      preadyReg <= firstAcc;
      pslverrReg <= firstAcc & ~mapped;
      if (firstAcc) begin
        prdataReg <= pwrite ? '0 : rdMux;
      end
    end
  end

  // Stack sequencer and stack pointer
  wire logic stkIdle = (stkReg == STK_IDLE);
  always_comb begin
    stkNext = stkReg;
    spNext = spReg;
    retNext = retReg;
    savedNext = savedRet;
    memNext = '0;
    memNext.addr = memReg.addr;
    case (stkReg)
      STK_IDLE: begin
        if (coreOp.longCall) begin
          savedNext = retReg;
          retNext = coreOp.callRet;
          memNext.addr = {16'h0000, spReg};
          memNext.wdata = retReg[15:0];
          memNext.we = 1'b1;
          spNext = spReg + SP_ONE;
          stkNext = STK_WR_HI;
        end else if (coreOp.longRet) begin
          memNext.addr = {16'h0000, 16'(spReg - SP_ONE)};
          memNext.re = 1'b1;
          spNext = spReg - SP_ONE;
          stkNext = STK_RD_HI;
        end else if (coreOp.spAdj) begin
          spNext = spReg + coreOp.spDelta;
        end else if (spWr) begin
          spNext = pwdata[15:0];
        end
        if (retWr && !coreOp.longCall && !coreOp.longRet) begin
          retNext = pwdata[21:0];
        end
      end
      STK_WR_HI: begin
        memNext.addr = {16'h0000, spReg};
        memNext.wdata = {10'h000, savedRet[21:16]};
        memNext.we = 1'b1;
        spNext = spReg + SP_ONE;
        stkNext = STK_IDLE;
      end
      STK_RD_HI: begin
        memNext.addr = {16'h0000, 16'(spReg - SP_ONE)};
        memNext.re = 1'b1;
        spNext = spReg - SP_ONE;
        stkNext = STK_RD_LO;
      end
      STK_RD_LO: begin
        retNext = {memRdata[5:0], retReg[15:0]};
        stkNext = STK_RD_DONE;
      end
      STK_RD_DONE: begin
        retNext = {retReg[21:16], memRdata};
        stkNext = STK_IDLE;
      end
      default: stkNext = STK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stkReg <= STK_IDLE;
      spReg <= SP_RESET;
      retReg <= RET_RESET;
      savedRet <= RET_RESET;
      memReg <= '0;
      busyReg <= 1'b0;
    end else begin
      stkReg <= stkNext;
      spReg <= spNext;
      retReg <= retNext;
      savedRet <= savedNext;
      memReg <= memNext;
      busyReg <= (stkNext != STK_IDLE);
    end
  end

  // Branch target for the long return
  always_ff @(posedge clk) begin
    if (rst) begin
      branchReg <= 1'b0;
      branchAddrReg <= RET_RESET;
    end else begin
      branchReg <= stkIdle & coreOp.longRet & ~coreOp.longCall;
      if (stkIdle && coreOp.longRet && !coreOp.longCall) begin
        branchAddrReg <= retReg;
      end
    end
  end

  // Overflow tally and status word update
  wire logic satOn = execReg[OVM_BIT];
  wire logic [5:0] tally = execReg[OFL_HI:OFL_LO];
  wire logic tallyUp = !coreOp.cmpOp && (coreOp.unsignedOp ? coreOp.unsCarry :
      (coreOp.accOflPos && !satOn));
  wire logic tallyDn = !coreOp.cmpOp && (coreOp.unsignedOp ? coreOp.unsBorrow :
      (coreOp.accOflNeg && !satOn));
  wire logic vSet = !coreOp.cmpOp && !coreOp.unsignedOp &&
      (coreOp.accOflPos || coreOp.accOflNeg || coreOp.otherOfl);
  always_comb begin
    execNext = exWr ? pwdata[15:0] : execReg;
    if (tallyUp && !tallyDn) begin
      execNext[OFL_HI:OFL_LO] = tally + OFL_ONE;
    end else if (tallyDn && !tallyUp) begin
      execNext[OFL_HI:OFL_LO] = tally - OFL_ONE;
    end
    if (coreOp.flagWe) begin
      execNext[N_BIT] = coreOp.flagVal[3];
      execNext[Z_BIT] = coreOp.flagVal[2];
      execNext[C_BIT] = coreOp.flagVal[1];
      execNext[TC_BIT] = coreOp.flagVal[0];
    end
    if (coreOp.vTest) begin
      execNext[V_BIT] = 1'b0;
    end
    if (vSet) begin
      execNext[V_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      execReg <= EXEC_RESET;
    end else begin
      execReg <= execNext;
    end
  end

  // Product shifter
  wire logic [2:0] pm = execReg[PM_HI:PM_LO];
  wire logic [2:0] rshAmt = pm - PM_RIGHT_BASE;
  wire logic [31:0] prodShift = (pm == PM_LEFT1) ? {coreOp.prodIn[30:0], 1'b0} :
      (pm == PM_NONE) ? coreOp.prodIn :
      32'($signed(coreOp.prodIn) >>> rshAmt);
  always_ff @(posedge clk) begin
    if (rst) begin
      prodReg <= '0;
    end else begin
      prodReg <= prodShift;
    end
  end

  // Auxiliary pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < AUX_N; i++) begin
        auxReg[i] <= '0;
      end
    end else begin
      if (coreOp.auxLowWe) begin
        auxReg[coreOp.auxIdx][15:0] <= coreOp.auxLowData;
      end
      if (auxWr && !(coreOp.auxLowWe && coreOp.auxIdx == auxSel)) begin
        auxReg[auxSel] <= pwdata;
      end
    end
  end

  // Fetch counter follows the decode-two instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      fetchReg <= FETCH_RESET;
    end else if (coreOp.d2Advance) begin
      fetchReg <= coreOp.d2Addr;
    end
  end

  // Interrupt selection
  wire logic [15:0] eligible = pendReg & maskReg &
      (coreOp.halted ? haltReg : 16'hFFFF);
  wire logic canTake = (|eligible) && !coreOp.d2Busy && !irqTakeReg;
  logic [3:0] pick;
  always_comb begin
    pick = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (eligible[i]) begin
        pick = 4'(i);
      end
    end
  end
  wire logic [15:0] takeMask = canTake ? (16'h0001 << pick) : 16'h0000;
  wire logic [15:0] swClr = pendClrWr ? pwdata[15:0] : 16'h0000;
  wire logic [15:0] swSet = pendWr ? pwdata[15:0] : 16'h0000;

  // Pending flags: a new request wins over a clear
  assign pendNext = (pendReg & ~swClr & ~takeMask) | coreOp.irqRaise | swSet;

  always_ff @(posedge clk) begin
    if (rst) begin
      pendReg <= '0;
      maskReg <= '0;
      haltReg <= '0;
      irqTakeReg <= 1'b0;
      irqNumReg <= '0;
    end else begin
      pendReg <= pendNext;
      irqTakeReg <= canTake;
      if (canTake) begin
        irqNumReg <= pick;
      end
      if (maskWr) begin
        maskReg <= pwdata[15:0];
      end
      if (haltWr) begin
        haltReg <= pwdata[15:0];
      end
    end
  end

  // Output drive
  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign memPort = memReg;
  assign stackBusy = busyReg;
  assign branchStb = branchReg;
  assign branchAddr = branchAddrReg;
  assign prodOut = prodReg;
  assign irqTake = irqTakeReg;
  assign irqNum = irqNumReg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_call_lo;
    memReg.we && memReg.wdata == $past(retReg[15:0]);
  endsequence
  sequence s_call_hi;
    memReg.we && memReg.addr[15:0] == $past(memReg.addr[15:0]) + SP_ONE;
  endsequence

  chk_sp_reset_val: assert property ($fell(rst) |-> spReg == SP_RESET)
    else $error("stack pointer reset value wrong");
  chk_addr_upper_zero: assert property ((memReg.we || memReg.re)
      |-> memReg.addr[31:16] == 16'h0000)
    else $error("stack address upper bits not zero");
  chk_call_push_order: assert property (stkIdle && coreOp.longCall
      |=> s_call_lo ##1 s_call_hi)
    else $error("long call push order wrong");
  chk_call_sp_step: assert property (stkIdle && coreOp.longCall
      |=> ##1 spReg == $past(spReg, 2) + 16'h0002)
    else $error("long call stack pointer step wrong");
  chk_sp_wrap_add: assert property (stkIdle && !coreOp.longCall && !coreOp.longRet
      && coreOp.spAdj |=> spReg == 16'($past(spReg) + $past(coreOp.spDelta)))
    else $error("stack pointer arithmetic wrong");
  chk_ret_untouched: assert property (stkIdle && !coreOp.longCall && !coreOp.longRet
      && !retWr |=> $stable(retReg))
    else $error("return address changed without long call");
  chk_ret_branch: assert property (stkIdle && coreOp.longRet && !coreOp.longCall
      |=> branchStb && branchAddr == $past(retReg) ##3 stkIdle)
    else $error("long return sequence wrong");
  chk_tally_sat_hold: assert property (!exWr && !coreOp.unsignedOp && satOn
      && !coreOp.cmpOp |=> $stable(execReg[OFL_HI:OFL_LO]))
    else $error("tally changed in saturate mode");
  chk_tally_pos_inc: assert property (!exWr && !coreOp.unsignedOp && !satOn
      && !coreOp.cmpOp && coreOp.accOflPos && !coreOp.accOflNeg
      |=> execReg[OFL_HI:OFL_LO] == $past(tally) + OFL_ONE && execReg[V_BIT])
    else $error("tally not incremented with V");
  chk_cmp_no_tally: assert property (!exWr && coreOp.cmpOp && !coreOp.vTest
      |=> $stable(execReg[OFL_HI:V_BIT]))
    else $error("compare changed tally or V");
  chk_v_clear_test: assert property (!exWr && coreOp.vTest && !vSet |=> !execReg[V_BIT])
    else $error("V not cleared by branch test");
  chk_irq_masked: assert property (irqTake |-> |($past(maskReg) & (16'h1 << irqNum)))
    else $error("interrupt taken while masked");
  chk_irq_halt: assert property (irqTake && $past(coreOp.halted)
      |-> |($past(haltReg) & (16'h1 << irqNum)))
    else $error("halted interrupt not time-critical");
  chk_irq_d2_wait: assert property (coreOp.d2Busy |=> !irqTake)
    else $error("interrupt taken before decode-two done");

endmodule : sas_regs
`default_nettype wire

// ==== test/sas_stack_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module sas_stack_mem
  import sas_pkg::*;
(
  // Clock
  input wire logic clk,
  // Core stack port
  input wire sas_mem_s memPort,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:65535];

  // Word store and one-cycle read; idle data toggles so stale reads show
  // 16-bit halves keep their full address; no access drops bit 0
  always @(posedge clk) begin
    if (memPort.we === 1'h1) begin
      mem[memPort.addr[15:0]] <= memPort.wdata;
    end
    if (memPort.re === 1'h1) begin
      memRdata <= mem[memPort.addr[15:0]];
    end else begin
      memRdata <= ~memRdata;
    end
  end

  // Known start value for the toggling idle data
  initial begin
    memRdata = 16'h0000;
  end
endmodule : sas_stack_mem
`default_nettype wire

// ==== test/stack_aux_status_regs_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module stack_aux_status_regs_tb_top;
  import sas_pkg::*;
  localparam logic [31:0] PROD_IN = 32'h8000_0010;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, prodOut;
  sas_core_op_s op, opIdle;
  sas_mem_s memPort;
  logic [15:0] memRdata;
  logic stackBusy, branchStb, irqTake;
  logic [21:0] branchAddr;
  logic [3:0] irqNum, lastNum;
  int failCount, checked, takes;

  // Block under test and its stack memory
  sas_regs u_sas_regs (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreOp(op), .memRdata(memRdata),
    .memPort(memPort), .stackBusy(stackBusy), .branchStb(branchStb),
    .branchAddr(branchAddr), .prodOut(prodOut), .irqTake(irqTake),
    .irqNum(irqNum));
  sas_stack_mem u_sas_stack_mem (.clk(clk), .memPort(memPort), .memRdata(memRdata));

  // Clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Stack address watch and interrupt tally
  always @(posedge clk) begin
    if (memPort.we === 1'h1 || memPort.re === 1'h1) `CHK(memPort.addr[31:16], 16'h0000)
    if (irqTake === 1'h1) begin
      takes <= takes + 1;
      lastNum <= irqNum;
    end
  end

  task endOfTest;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : endOfTest

  task tmo;
    failCount++;
    endOfTest();
  endtask : tmo

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) tmo();
    rdat = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd

  // Holds a core request one edge, then idles it
  task step;
    @(posedge clk);
    op <= opIdle;
    @(posedge clk);
  endtask : step

  task waitTake(input int t0);
    for (int n = 0; n < 10 && takes == t0; n++) @(posedge clk);
    if (takes == t0) tmo();
  endtask : waitTake

  task tReset;
    rd(OFF_STACK_PTR, 32'h0000_0400);
    rd(OFF_EXEC_STATUS, 32'h0000_0000);
    rd(OFF_FETCH_CNT, 32'h003F_FFC0);
    wr(OFF_EXEC_STATUS, 32'h0000_FFFF);
    rd(OFF_EXEC_STATUS, 32'h0000_FFFF);
    wr(OFF_EXEC_STATUS, 32'h0000_0000);
    op.d2Advance <= 1'h1;
    op.d2Addr <= 22'h0155AA;
    step();
    rd(OFF_FETCH_CNT, 32'h0001_55AA);
  endtask : tReset

  task tSpWrap;
    wr(OFF_STACK_PTR, 32'h0000_FFFE);
    op.spAdj <= 1'h1;
    op.spDelta <= 16'h0003;
    step();
    rd(OFF_STACK_PTR, 32'h0000_0001);
    wr(OFF_STACK_PTR, 32'h0000_0002);
    op.spAdj <= 1'h1;
    op.spDelta <= 16'hFFFC;
    step();
    rd(OFF_STACK_PTR, 32'h0000_FFFE);
  endtask : tSpWrap

  task tCallRet;
    wr(OFF_STACK_PTR, 32'h0000_0083);
    wr(OFF_RET_ADDR, 32'h0002_ABCD);
    op.longCall <= 1'h1;
    op.callRet <= 22'h012345;
    step();
    `CHK(stackBusy, 1'h1)
    repeat (3) @(posedge clk);
    `CHK(u_sas_stack_mem.mem[16'h0083], 16'hABCD)
    `CHK(u_sas_stack_mem.mem[16'h0084], 16'h0002)
    `CHK(stackBusy, 1'h0)
    rd(OFF_RET_ADDR, 32'h0001_2345);
    rd(OFF_STACK_PTR, 32'h0000_0085);
    op.longRet <= 1'h1;
    @(posedge clk);
    op.longRet <= 1'h0;
    for (int n = 0; n < 6 && branchStb !== 1'h1; n++) @(posedge clk);
    if (branchStb !== 1'h1) tmo();
    `CHK(stackBusy, 1'h1)
    `CHK(branchAddr, 22'h012345)
    repeat (6) @(posedge clk);
    rd(OFF_RET_ADDR, 32'h0002_ABCD);
    rd(OFF_STACK_PTR, 32'h0000_0083);
  endtask : tCallRet

  task tAux;
    wr(OFF_AUX_BASE + 8'h0C, 32'hA5A5_0000);
    op.auxLowWe <= 1'h1;
    op.auxIdx <= 3'h3;
    op.auxLowData <= 16'h1234;
    step();
    rd(OFF_AUX_BASE + 8'h0C, 32'hA5A5_1234);
    wr(OFF_AUX_LAST, 32'hFFFF_0001);
    rd(OFF_AUX_LAST, 32'hFFFF_0001);
    apb(1'h0, 8'h21, 32'h0);
    `CHK(perr, 1'h1)
  endtask : tAux

  task tTally;
    op.accOflPos <= 1'h1;
    repeat (32) @(posedge clk);
    op.accOflPos <= 1'h0;
    @(posedge clk);
    rd(OFF_EXEC_STATUS, 32'h0000_8040);
    op.accOflNeg <= 1'h1;
    step();
    op.vTest <= 1'h1;
    step();
    rd(OFF_EXEC_STATUS, 32'h0000_7C00);
    op.otherOfl <= 1'h1;
    step();
    op.cmpOp <= 1'h1;
    op.accOflPos <= 1'h1;
    step();
    rd(OFF_EXEC_STATUS, 32'h0000_7C40);
    op.unsignedOp <= 1'h1;
    op.unsCarry <= 1'h1;
    step();
    rd(OFF_EXEC_STATUS, 32'h0000_8040);
    op.unsignedOp <= 1'h1;
    op.unsBorrow <= 1'h1;
    step();
    rd(OFF_EXEC_STATUS, 32'h0000_7C40);
    wr(OFF_EXEC_STATUS, 32'h0000_0002);
    op.accOflPos <= 1'h1;
    step();
    apb(1'h0, OFF_EXEC_STATUS, 32'h0);
    `CHK(rdat[15:10], 6'h00)
    op.flagWe <= 1'h1;
    op.flagVal <= 4'hA;
    step();
    rd(OFF_EXEC_STATUS, 32'h0000_006A);
  endtask : tTally

  task tShift;
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      wr(OFF_EXEC_STATUS, 32'(k) << 7);
      repeat (2) @(posedge clk);
      case (k)
        0: e = 32'h0000_0020;
        1: e = PROD_IN;
        2: e = 32'hC000_0008;
        3: e = 32'hE000_0004;
        4: e = 32'hF000_0002;
        5: e = 32'hF800_0001;
        6: e = 32'hFC00_0000;
        default: e = 32'hFE00_0000;
      endcase
      `CHK(prodOut, e)
    end
  endtask : tShift

  task tIrq;
    int t0;
    op.irqRaise <= 16'h0020;
    step();
    t0 = takes;
    repeat (6) @(posedge clk);
    `CHK(takes, t0)
    wr(OFF_IRQ_MASK, 32'h0000_0020);
    waitTake(t0);
    `CHK(lastNum, 4'h5)
    rd(OFF_IRQ_PEND, 32'h0000_0000);
    wr(OFF_IRQ_PEND, 32'h0000_0008);
    rd(OFF_IRQ_PEND, 32'h0000_0008);
    wr(OFF_IRQ_PEND_CLR, 32'h0000_0008);
    rd(OFF_IRQ_PEND, 32'h0000_0000);
    opIdle.halted = 1'h1;
    opIdle.d2Busy = 1'h1;
    op <= opIdle;
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    wr(OFF_IRQ_PEND, 32'h0000_0004);
    t0 = takes;
    repeat (6) @(posedge clk);
    `CHK(takes, t0)
    wr(OFF_HALT_MASK, 32'h0000_0004);
    repeat (6) @(posedge clk);
    `CHK(takes, t0)
    opIdle.d2Busy = 1'h0;
    op <= opIdle;
    waitTake(t0);
    `CHK(lastNum, 4'h2)
  endtask : tIrq

  // Main sequence
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    opIdle = '0;
    opIdle.prodIn = PROD_IN;
    op = opIdle;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    tReset();
    tSpWrap();
    tCallRet();
    tAux();
    tTally();
    tShift();
    tIrq();
    endOfTest();
  end
endmodule : stack_aux_status_regs_tb_top
`default_nettype wire
